// file: rtl/rsr_cfg.svh
`ifndef RSR_CFG_SVH
`define RSR_CFG_SVH
`define RSR_OFF_CMD 8'h00
`define RSR_OFF_ACC 8'h04
`define RSR_OFF_STAT 8'h08
`define RSR_OFF_PC 8'h0C
`define RSR_OFF_STK 8'h10
`define RSR_OFF_PUSH 8'h14
`define RSR_OFF_FADR 8'h18
`define RSR_OFF_FDAT 8'h1C
`define RSR_OFF_SADR 8'h20
`define RSR_OFF_SDAT 8'h24
`define RSR_STK_BUSY_BIT 8
`define RSR_STK_DEPTH 4'h8
`define RSR_SPAGE_LAST 5'h15
`define RSR_RESP_OK 2'h0
`define RSR_RESP_ERR 2'h2
`define RSR_PC_RST 11'h000
`define RSR_ACC_RST 8'h00
`endif

// file: rtl/rsr_exec.sv
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "rsr_cfg.svh"
module rsr_exec (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    import rsr_pkg::*;

    logic [1:0] rstSync_r;
    logic [7:0] acc_r;
    rsr_flags_s flags_r;
    logic [10:0] pc_r;
    logic [10:0] stack_r [0:7];
    logic [3:0] level_r;
    logic [7:0] fileMem [0:127];
    logic [7:0] spage_r [0:21];
    rsr_cmd_s cmd_r;
    rsr_state_e state_r;
    logic [6:0] fileSel_r;
    logic [4:0] spageSel_r;
    logic [7:0] wAddr_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic awHave_r;
    logic wHave_r;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) rstSync_r <= 2'h0;
        else rstSync_r <= {rstSync_r[0], 1'b1};
    end
    wire rstnInt = rstSync_r[1];

    // Write channel: address and data are caught in either order.
    wire doWrite = awHave_r && wHave_r && !bvalid && state_r == ST_IDLE;
    wire hitCmd = wAddr_r == `RSR_OFF_CMD;
    wire hitAcc = wAddr_r == `RSR_OFF_ACC;
    wire hitStat = wAddr_r == `RSR_OFF_STAT;
    wire hitPc = wAddr_r == `RSR_OFF_PC;
    wire hitPush = wAddr_r == `RSR_OFF_PUSH;
    wire hitFadr = wAddr_r == `RSR_OFF_FADR;
    wire hitFdat = wAddr_r == `RSR_OFF_FDAT;
    wire hitSadr = wAddr_r == `RSR_OFF_SADR;
    wire wMapped = hitCmd | hitAcc | hitStat | hitPc | hitPush | hitFadr
        | hitFdat | hitSadr;
    wire wEn = doWrite && wMapped && wStrb_r == 4'hF;

    always_ff @(posedge mclk or negedge rstnInt) begin
        if (!rstnInt) begin
            awready <= 1'b1;
            awHave_r <= 1'b0;
            wAddr_r <= 8'h00;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            awHave_r <= 1'b1;
            wAddr_r <= awaddr;
        end else if (bvalid && bready) begin
            awready <= 1'b1;
            awHave_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstnInt) begin
        if (!rstnInt) begin
            wready <= 1'b1;
            wHave_r <= 1'b0;
            wData_r <= 32'h0000_0000;
            wStrb_r <= 4'h0;
        end else if (wvalid && wready) begin
            wready <= 1'b0;
            wHave_r <= 1'b1;
            wData_r <= wdata;
            wStrb_r <= wstrb;
        end else if (bvalid && bready) begin
            wready <= 1'b1;
            wHave_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstnInt) begin
        if (!rstnInt) begin
            bvalid <= 1'b0;
            bresp <= `RSR_RESP_OK;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            bresp <= wMapped ? `RSR_RESP_OK : `RSR_RESP_ERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Instruction datapath.
    wire exec = state_r == ST_EXEC;
    wire [7:0] srcFile = fileMem[cmd_r.fileAddr];
    wire isLeft = cmd_r.op == OP_ROTATE_LEFT;
    wire isRot = isLeft || cmd_r.op == OP_ROTATE_RIGHT;
    wire isImm = cmd_r.op == OP_SUB_BORROW_IMM;
    wire isSub = isImm || cmd_r.op == OP_SUB_BORROW_REG;
    wire isRet = cmd_r.op == OP_RETURN;
    wire isStore = cmd_r.op == OP_SPAGE_STORE;
    wire [7:0] rotL = {srcFile[6:0], flags_r.carry};
    wire [7:0] rotR = {flags_r.carry, srcFile[7:1]};
    wire [7:0] rotRes = isLeft ? rotL : rotR;
    wire rotCarry = isLeft ? srcFile[7] : srcFile[0];
    wire [7:0] subA = isImm ? cmd_r.imm : srcFile;
    wire [9:0] sbcRes = rsr_sbc(subA, acc_r, flags_r.carry);
    wire [7:0] result = isRot ? rotRes : sbcRes[7:0];
    wire toFile = (isRot || (isSub && !isImm)) && cmd_r.toFile;
    wire toAcc = (isRot || isSub) && !toFile;
    wire [2:0] topIdx = 3'(level_r - 4'h1);
    wire [10:0] topEntry = stack_r[topIdx];
    wire canPop = level_r != 4'h0;
    wire storeOk = isStore && cmd_r.imm <= {3'h0, `RSR_SPAGE_LAST};
    wire pushOk = wEn && hitPush && level_r != `RSR_STK_DEPTH;

    always_ff @(posedge mclk or negedge rstnInt) begin
        if (!rstnInt) begin
            state_r <= ST_IDLE;
            cmd_r <= '0;
        end else begin
            case (state_r)
                ST_IDLE: if (wEn && hitCmd) begin
                    cmd_r <= rsr_cmd_s'(wData_r[18:0]);
                    state_r <= rsr_op_e'(wData_r[18:16]) == OP_RETURN
                        ? ST_RET_WAIT : ST_EXEC;
                end
                ST_RET_WAIT: state_r <= ST_EXEC;
                ST_EXEC: state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstnInt) begin
        if (!rstnInt) acc_r <= `RSR_ACC_RST;
        else if (wEn && hitAcc) acc_r <= wData_r[7:0];
        else if (exec && toAcc) acc_r <= result;
    end

    always_ff @(posedge mclk or negedge rstnInt) begin
        if (!rstnInt) flags_r <= '0;
        else if (wEn && hitStat) flags_r <= rsr_flags_s'(wData_r[2:0]);
        else if (exec && isRot) flags_r.carry <= rotCarry;
        else if (exec && isSub) begin
            flags_r.carry <= sbcRes[9];
            flags_r.nibbleBorrow <= sbcRes[8];
            flags_r.zero <= sbcRes[7:0] == 8'h00;
        end
    end

    always_ff @(posedge mclk or negedge rstnInt) begin
        if (!rstnInt) begin
            pc_r <= `RSR_PC_RST;
            level_r <= 4'h0;
        end else if (wEn && hitPc) begin
            pc_r <= wData_r[10:0];
        end else if (pushOk) begin
            level_r <= 4'(level_r + 4'h1);
        end else if (exec && isRet) begin
            if (canPop) begin
                pc_r <= topEntry;
                level_r <= 4'(level_r - 4'h1);
            end
        end else if (exec) begin
            pc_r <= 11'(pc_r + 11'h001);
        end
    end

    always_ff @(posedge mclk) begin
        if (pushOk) stack_r[level_r[2:0]] <= wData_r[10:0];
        if (exec && toFile) fileMem[cmd_r.fileAddr] <= result;
        else if (wEn && hitFdat) fileMem[fileSel_r] <= wData_r[7:0];
    end

    always_ff @(posedge mclk or negedge rstnInt) begin
        if (!rstnInt) begin
            for (int i = 0; i <= int'(`RSR_SPAGE_LAST); i++) spage_r[i] <= 8'h00;
        end else if (exec && storeOk) begin
            spage_r[cmd_r.imm[4:0]] <= acc_r;
        end
    end

    always_ff @(posedge mclk or negedge rstnInt) begin
        if (!rstnInt) begin
            fileSel_r <= 7'h00;
            spageSel_r <= 5'h00;
        end else if (wEn && hitFadr) begin
            fileSel_r <= wData_r[6:0];
        end else if (wEn && hitSadr) begin
            spageSel_r <= wData_r[4:0];
        end
    end

    // Read channel: one read at a time, answered the cycle after it is taken.
    wire [7:0] spageRd = spageSel_r <= `RSR_SPAGE_LAST
        ? spage_r[spageSel_r] : 8'h00;
    wire [31:0] stkRd = {23'h0, state_r != ST_IDLE, 4'h0, level_r};
    wire rMapped = araddr == `RSR_OFF_CMD || araddr == `RSR_OFF_ACC
        || araddr == `RSR_OFF_STAT || araddr == `RSR_OFF_PC
        || araddr == `RSR_OFF_STK || araddr == `RSR_OFF_FADR
        || araddr == `RSR_OFF_FDAT || araddr == `RSR_OFF_SADR
        || araddr == `RSR_OFF_SDAT;
    wire [31:0] rdMux =
        araddr == `RSR_OFF_CMD ? {13'h0, cmd_r} :
        araddr == `RSR_OFF_ACC ? {24'h0, acc_r} :
        araddr == `RSR_OFF_STAT ? {29'h0, flags_r} :
        araddr == `RSR_OFF_PC ? {21'h0, pc_r} :
        araddr == `RSR_OFF_STK ? stkRd :
        araddr == `RSR_OFF_FADR ? {25'h0, fileSel_r} :
        araddr == `RSR_OFF_FDAT ? {24'h0, fileMem[fileSel_r]} :
        araddr == `RSR_OFF_SADR ? {27'h0, spageSel_r} :
        araddr == `RSR_OFF_SDAT ? {24'h0, spageRd} : 32'h0000_0000;

    always_ff @(posedge mclk or negedge rstnInt) begin
        if (!rstnInt) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RSR_RESP_OK;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rdMux;
            rresp <= rMapped ? `RSR_RESP_OK : `RSR_RESP_ERR;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
        end
    end

    chk_rotl_carry_out: assert property (@(posedge mclk)
        disable iff (!rstnInt) exec && isLeft |=>
        flags_r.carry == $past(srcFile[7])
        && flags_r.zero == $past(flags_r.zero))
        else $error("Left rotate carry or other flag wrong.");

    chk_rotr_acc_value: assert property (@(posedge mclk)
        disable iff (!rstnInt)
        exec && cmd_r.op == OP_ROTATE_RIGHT && !cmd_r.toFile |=>
        acc_r == {$past(flags_r.carry), $past(srcFile[7:1])}
        && flags_r.carry == $past(srcFile[0]))
        else $error("Right rotate result wrong.");

    chk_dest_file_keeps: assert property (@(posedge mclk)
        disable iff (!rstnInt) exec && isRot && cmd_r.toFile |=>
        acc_r == $past(acc_r)
        && fileMem[$past(cmd_r.fileAddr)] == $past(result))
        else $error("File destination touched the accumulator.");

    chk_return_pc_load: assert property (@(posedge mclk)
        disable iff (!rstnInt) state_r == ST_RET_WAIT && canPop |=>
        exec ##1 pc_r == $past(topEntry, 2)
        && flags_r == $past(flags_r, 2))
        else $error("Return did not load the stack top in two cycles.");

    chk_return_level_drop: assert property (@(posedge mclk)
        disable iff (!rstnInt) exec && isRet && canPop |=>
        level_r == 4'($past(level_r) - 4'h1))
        else $error("Return did not lower the stack level.");

    chk_sbc_reg_value: assert property (@(posedge mclk)
        disable iff (!rstnInt)
        exec && cmd_r.op == OP_SUB_BORROW_REG && !cmd_r.toFile |=>
        acc_r == 8'($past(srcFile) - $past(acc_r)
        - {7'h0, !$past(flags_r.carry)}))
        else $error("Register subtract with borrow result wrong.");

    chk_sbc_carry_zero: assert property (@(posedge mclk)
        disable iff (!rstnInt) exec && isSub && !toFile |=>
        flags_r.carry == ({1'b0, $past(subA)} >= 9'({1'b0, $past(acc_r)}
        + {8'h0, !$past(flags_r.carry)}))
        && flags_r.zero == (acc_r == 8'h00))
        else $error("Subtract carry or zero flag wrong.");

    chk_sbc_imm_value: assert property (@(posedge mclk)
        disable iff (!rstnInt) exec && isImm |=>
        acc_r == 8'($past(cmd_r.imm) - $past(acc_r)
        - {7'h0, !$past(flags_r.carry)}))
        else $error("Immediate subtract with borrow result wrong.");

    chk_spage_store_copy: assert property (@(posedge mclk)
        disable iff (!rstnInt) exec && storeOk |=>
        spage_r[$past(cmd_r.imm[4:0])] == $past(acc_r)
        && flags_r == $past(flags_r))
        else $error("S-page store failed or changed flags.");

    chk_nibble_borrow_flag: assert property (@(posedge mclk)
        disable iff (!rstnInt) exec && isSub |=>
        flags_r.nibbleBorrow == ({1'b0, $past(subA[3:0])} >=
        5'({1'b0, $past(acc_r[3:0])} + {4'h0, !$past(flags_r.carry)})))
        else $error("Nibble borrow flag wrong.");
endmodule : rsr_exec
`default_nettype wire

// file: rtl/rsr_pkg.sv
`default_nettype none
package rsr_pkg;
    typedef enum logic [2:0] {
        OP_NOP, OP_ROTATE_LEFT, OP_ROTATE_RIGHT, OP_RETURN,
        OP_SUB_BORROW_REG, OP_SUB_BORROW_IMM, OP_SPAGE_STORE
    } rsr_op_e;
    typedef enum logic [1:0] {ST_IDLE, ST_RET_WAIT, ST_EXEC} rsr_state_e;
    typedef struct packed {
        rsr_op_e op;
        logic toFile;
        logic [6:0] fileAddr;
        logic [7:0] imm;
    } rsr_cmd_s;
    typedef struct packed {
        logic zero;
        logic nibbleBorrow;
        logic carry;
    } rsr_flags_s;

    // Returns {carry, nibble carry, result} of a + ~acc + c.
    function automatic logic [9:0] rsr_sbc(input logic [7:0] a,
                                           input logic [7:0] acc,
                                           input logic c);
        logic [4:0] lo;
        logic [4:0] hi;
        lo = {1'b0, a[3:0]} + {1'b0, ~acc[3:0]} + {4'h0, c};
        hi = {1'b0, a[7:4]} + {1'b0, ~acc[7:4]} + {4'h0, lo[4]};
        return {hi[4], lo[4], hi[3:0], lo[3:0]};
    endfunction : rsr_sbc
endpackage : rsr_pkg
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "rsr_cfg.svh"
module tb;
    import rsr_pkg::*;
    typedef struct packed {
        rsr_op_e op;
        logic dst;
        logic [7:0] imm, acc, r;
        logic [2:0] st;
        logic [7:0] eAcc, eR;
        logic [2:0] eSt;
    } rsr_row_s;
    logic mclk = 1'h0;
    logic rstn = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF, strb = 4'hF;
    wire logic awready, wready, bvalid, arready, rvalid;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    logic [1:0] resp;
    logic [31:0] rv, pc0;
    logic [6:0] fa;
    int n_fail = 0;
    int checked = 0;
    rsr_row_s rows [10] = '{
        '{OP_ROTATE_LEFT, 1'h1, 8'h00, 8'h11, 8'hA5, 3'h6, 8'h11, 8'h4A, 3'h7},
        '{OP_ROTATE_RIGHT, 1'h1, 8'h00, 8'h11, 8'hA5, 3'h6, 8'h11, 8'h52, 3'h7},
        '{OP_ROTATE_LEFT, 1'h0, 8'h00, 8'h22, 8'h80, 3'h3, 8'h01, 8'h80, 3'h3},
        '{OP_ROTATE_RIGHT, 1'h0, 8'h00, 8'h22, 8'h01, 3'h6, 8'h00, 8'h01, 3'h7},
        '{OP_SUB_BORROW_REG, 1'h1, 8'h00, 8'h06, 8'h05, 3'h6, 8'h06, 8'hFE, 3'h0},
        '{OP_SUB_BORROW_REG, 1'h1, 8'h00, 8'h06, 8'h05, 3'h7, 8'h06, 8'hFF, 3'h0},
        '{OP_SUB_BORROW_REG, 1'h0, 8'h00, 8'h05, 8'h06, 3'h0, 8'h00, 8'h06, 3'h7},
        '{OP_SUB_BORROW_IMM, 1'h1, 8'h06, 8'h05, 8'h33, 3'h1, 8'h01, 8'h33, 3'h3},
        '{OP_SUB_BORROW_IMM, 1'h0, 8'h05, 8'h06, 8'h33, 3'h4, 8'hFE, 8'h33, 3'h0},
        '{OP_SUB_BORROW_REG, 1'h0, 8'h00, 8'h01, 8'h10, 3'h1, 8'h0F, 8'h10, 3'h1}
    };
    always #20 mclk = ~mclk;
    rsr_exec u_dut (.mclk(mclk), .rstn(rstn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready));
    task automatic chk(input logic [31:0] g, input logic [31:0] e,
                       input string m);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    // Handshake state is judged at the falling edge, where it equals what
    // the next rising edge samples, and acted on at that rising edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic ta, tw, tb;
        n = 0;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= strb;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(negedge mclk);
            n++;
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid & bready;
            resp = bresp;
            @(posedge mclk);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
        end while (!tb && n < 200);
        bready <= 1'h0;
        if (!tb) chk(32'h1, 32'h0, "write hang");
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int n;
        logic ta, tr;
        n = 0;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(negedge mclk);
            n++;
            ta = arvalid & arready;
            tr = rvalid & rready;
            rv = rdata;
            resp = rresp;
            @(posedge mclk);
            if (ta) arvalid <= 1'h0;
        end while (!tr && n < 200);
        rready <= 1'h0;
        if (!tr) chk(32'h1, 32'h0, "read hang");
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [31:0] e,
                      input string m);
        rd(a);
        chk({30'h0, resp}, {30'h0, `RSR_RESP_OK}, m);
        chk(rv, e, m);
    endtask : rc
    task automatic cmd(input rsr_op_e op, input logic dst,
                       input logic [6:0] f, input logic [7:0] imm);
        wr(`RSR_OFF_CMD, {13'h0, op, dst, f, imm});
    endtask : cmd
    task test_done;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        $display("mismatch %0t watchdog expired", $time);
        test_done();
    end
    initial begin
        repeat (8) @(posedge mclk);
        rstn <= 1'h1;
        repeat (3) @(posedge mclk);
        rc(`RSR_OFF_ACC, 32'h0, "acc reset");
        rc(`RSR_OFF_PC, 32'h0, "pc reset");
        for (int i = 0; i < 10; i++) begin
            fa = 7'h70 + 7'(i);
            wr(`RSR_OFF_FADR, {25'h0, fa});
            wr(`RSR_OFF_FDAT, {24'h0, rows[i].r});
            wr(`RSR_OFF_ACC, {24'h0, rows[i].acc});
            wr(`RSR_OFF_STAT, {29'h0, rows[i].st});
            rd(`RSR_OFF_PC);
            pc0 = rv;
            cmd(rows[i].op, rows[i].dst, fa, rows[i].imm);
            wr(`RSR_OFF_FADR, {25'h0, fa});
            rc(`RSR_OFF_ACC, {24'h0, rows[i].eAcc}, "acc");
            rc(`RSR_OFF_FDAT, {24'h0, rows[i].eR}, "file");
            rc(`RSR_OFF_STAT, {29'h0, rows[i].eSt}, "flags");
            rc(`RSR_OFF_PC, {21'h0, pc0[10:0] + 11'h1}, "pc step");
        end
        wr(`RSR_OFF_ACC, 32'hAA);
        wr(`RSR_OFF_STAT, 32'h2);
        cmd(OP_SPAGE_STORE, 1'h0, 7'h00, 8'h15);
        wr(`RSR_OFF_ACC, 32'h55);
        cmd(OP_SPAGE_STORE, 1'h0, 7'h00, 8'h16);
        cmd(OP_SPAGE_STORE, 1'h0, 7'h00, 8'h00);
        wr(`RSR_OFF_SADR, 32'h15);
        rc(`RSR_OFF_SDAT, 32'hAA, "spage last");
        wr(`RSR_OFF_SADR, 32'h16);
        rc(`RSR_OFF_SDAT, 32'h0, "spage beyond");
        wr(`RSR_OFF_SADR, 32'h00);
        rc(`RSR_OFF_SDAT, 32'h55, "spage first");
        rc(`RSR_OFF_STAT, 32'h2, "spage flags");
        wr(`RSR_OFF_PC, 32'h123);
        wr(`RSR_OFF_PUSH, 32'h055);
        wr(`RSR_OFF_PUSH, 32'h2AB);
        wr(`RSR_OFF_STAT, 32'h5);
        rc(`RSR_OFF_STK, 32'h2, "level two");
        cmd(OP_RETURN, 1'h0, 7'h00, 8'h00);
        wr(`RSR_OFF_SADR, 32'h00);
        rc(`RSR_OFF_PC, 32'h2AB, "return pc");
        rc(`RSR_OFF_STK, 32'h1, "return level");
        rc(`RSR_OFF_STAT, 32'h5, "return flags");
        cmd(OP_RETURN, 1'h0, 7'h00, 8'h00);
        cmd(OP_RETURN, 1'h0, 7'h00, 8'h00);
        wr(`RSR_OFF_SADR, 32'h00);
        rc(`RSR_OFF_PC, 32'h055, "second return");
        rc(`RSR_OFF_STK, 32'h0, "empty stack");
        rc(`RSR_OFF_CMD, 32'h0003_0000, "cmd readback");
        rc(`RSR_OFF_FADR, 32'h79, "fadr readback");
        rc(`RSR_OFF_SADR, 32'h0, "sadr readback");
        cmd(OP_NOP, 1'h0, 7'h00, 8'h00);
        wr(`RSR_OFF_SADR, 32'h00);
        rc(`RSR_OFF_PC, 32'h056, "nop pc");
        rc(`RSR_OFF_ACC, 32'h55, "nop acc");
        rc(`RSR_OFF_STAT, 32'h5, "nop flags");
        wr(8'h28, 32'h1);
        chk({30'h0, resp}, {30'h0, `RSR_RESP_ERR}, "unmapped write");
        rd(8'h28);
        chk({30'h0, resp}, {30'h0, `RSR_RESP_ERR}, "unmapped read");
        wr(`RSR_OFF_STK, 32'h3);
        chk({30'h0, resp}, {30'h0, `RSR_RESP_ERR}, "read-only write");
        strb = 4'h3;
        wr(`RSR_OFF_ACC, 32'h77);
        strb = 4'hF;
        rc(`RSR_OFF_ACC, 32'h55, "partial strobe");
        @(posedge mclk);
        rstn <= 1'h0;
        repeat (2) @(posedge mclk);
        rstn <= 1'h1;
        repeat (3) @(posedge mclk);
        rc(`RSR_OFF_ACC, 32'h0, "acc rereset");
        rc(`RSR_OFF_STAT, 32'h0, "flags rereset");
        rc(`RSR_OFF_PC, 32'h0, "pc rereset");
        test_done();
    end
endmodule : tb
`default_nettype wire
